// ### design/afb_cfg.svh
// Register offsets, field positions and reset values of the function box
`ifndef AFB_CFG_SVH
`define AFB_CFG_SVH
`define AFB_OFF_FIRST     8'h00
`define AFB_OFF_SECOND    8'h04
`define AFB_OFF_CTRL      8'h08
`define AFB_OFF_SUM       8'h0c
`define AFB_OFF_DIFFERENCE_OUT      8'h10
`define AFB_OFF_OR        8'h14
`define AFB_OFF_XOR       8'h18
`define AFB_OFF_AND       8'h1c
`define AFB_OFF_CMP1      8'h20
`define AFB_OFF_CMP2      8'h24
`define AFB_OFF_MSK1      8'h28
`define AFB_OFF_MSK2      8'h2c
`define AFB_OFF_COND      8'h30
`define AFB_CTRL_CARRY    0
`define AFB_CTRL_UNIT_LO  1
`define AFB_CTRL_UNIT_HI  2
`define AFB_CTRL_LEN_LO   3
`define AFB_CTRL_LEN_HI   7
`define AFB_LEN_MAX       5'h18
`define AFB_RST_OPERAND   24'h000000
`define AFB_RST_CTRL      8'hc0
`endif

// ### design/afb_pkg.sv
// Types shared by the function box files
package afb_pkg;
  typedef enum logic [1:0] {
    afb_unit_binary = 2'h0,
    afb_unit_digit  = 2'h1,
    afb_unit_rsvd   = 2'h2,
    afb_unit_byte   = 2'h3
  } afb_unit_type;

  typedef struct packed {
    logic [4:0]   operand_length;
    afb_unit_type unit;
    logic         carry_in_flag;
  } afb_ctrl_type;

  typedef struct packed {
    logic [23:0] sum_out;
    logic [23:0] difference_out;
    logic [23:0] or_result;
    logic [23:0] exclusive_or_result;
    logic [23:0] and_result;
    logic [23:0] first_complement;
    logic [23:0] second_complement;
    logic [23:0] first_masked;
    logic [23:0] second_masked;
    logic [3:0]  binary_condition_group;
    logic [3:0]  operand_compare_group;
    logic [3:0]  operand_state_group;
    logic        carry_out_level;
    logic        borrow_out_level;
  } afb_result_type;

  typedef enum logic [2:0] {
    afb_st_idle = 3'b001,
    afb_st_data = 3'b010,
    afb_st_wait = 3'b100
  } afb_phase_type;

  typedef struct packed {
    afb_phase_type phase;
    logic          write;
    logic [7:0]    addr;
  } afb_bus_type;

  typedef struct packed {
    logic [23:0]  first_operand;
    logic [23:0]  second_operand;
    afb_ctrl_type ctrl;
    logic [31:0]  rdata;
  } afb_regs_type;
endpackage

// ### design/afb_adder.sv
// Per-unit adder and subtractor of the function box
`timescale 1ns/1ps
module afb_adder
  import afb_pkg::*;
#(
  parameter int WIDTH = 24
) (
  input  wire logic [WIDTH-1:0] first_operand,
  input  wire logic [WIDTH-1:0] second_operand,
  input  wire logic             carry_in_flag,
  input  wire afb_unit_type     unit,
  output logic      [WIDTH-1:0] sum_out,
  output logic      [WIDTH-1:0] difference_out,
  output logic                  carry_out_level,
  output logic                  borrow_out_level
);
  // Digit add with decimal correction on a 4-bit unit
  function automatic logic [4:0] digit_add(input logic [3:0] a, input logic [3:0] b,
                                           input logic c);
    logic [4:0] raw;
    raw = {1'b0, a} + {1'b0, b} + {4'h0, c};
    if (raw > 5'h09) begin
      digit_add = raw + 5'h06;
    end else begin
      digit_add = raw;
    end
  endfunction

  // Digit subtract with decimal correction, top bit is borrow
  function automatic logic [4:0] digit_sub(input logic [3:0] a, input logic [3:0] b,
                                           input logic c);
    logic [4:0] raw;
    raw = {1'b0, a} - {1'b0, b} - {4'h0, c};
    if (raw[4]) begin
      digit_sub = {1'b1, 4'(raw[3:0] - 4'h6)};
    end else begin
      digit_sub = raw;
    end
  endfunction

  logic [WIDTH:0] bin_sum;
  logic [WIDTH:0] bin_difference_out;

  always_comb begin
    logic [4:0] dt;
    logic       cs;
    logic       cd;
    dt = 5'h00;
    cs = carry_in_flag;
    cd = carry_in_flag;
    bin_sum  = {1'b0, first_operand} + {1'b0, second_operand} + {{WIDTH{1'b0}}, carry_in_flag};
    bin_difference_out = {1'b0, first_operand} - {1'b0, second_operand} - {{WIDTH{1'b0}}, carry_in_flag};
    sum_out = bin_sum[WIDTH-1:0];
    difference_out = bin_difference_out[WIDTH-1:0];
    carry_out_level = bin_sum[WIDTH];
    borrow_out_level = bin_difference_out[WIDTH];
    if (unit == afb_unit_digit) begin
      for (int i = 0; i < WIDTH / 4; i++) begin
        dt = digit_add(first_operand[4*i +: 4], second_operand[4*i +: 4], cs);
        sum_out[4*i +: 4] = dt[3:0];
        cs = dt[4];
        dt = digit_sub(first_operand[4*i +: 4], second_operand[4*i +: 4], cd);
        difference_out[4*i +: 4] = dt[3:0];
        cd = dt[4];
      end
      carry_out_level = cs;
      borrow_out_level = cd;
    end
  end
endmodule

// ### design/afb_cond.sv
// Condition groups of the function box
`timescale 1ns/1ps
module afb_cond #(
  parameter int WIDTH = 24
) (
  input  wire logic [WIDTH-1:0] first_operand,
  input  wire logic [WIDTH-1:0] second_operand,
  input  wire logic [WIDTH-1:0] sum_out,
  input  wire logic             carry_out_level,
  input  wire logic             borrow_out_level,
  output logic      [3:0]       binary_condition_group,
  output logic      [3:0]       operand_compare_group,
  output logic      [3:0]       operand_state_group
);
  always_comb begin
    binary_condition_group = {carry_out_level, borrow_out_level, sum_out[WIDTH-1],
                              (sum_out == '0)};
    operand_compare_group = {(first_operand > second_operand),
                             (first_operand < second_operand),
                             (first_operand == second_operand),
                             ((first_operand & second_operand) == '0)};
    operand_state_group = {(first_operand == '0), (second_operand == '0),
                           first_operand[0], second_operand[0]};
  end
endmodule

// ### design/afb_top.sv
// Function box with its operand and control registers on an AHB-Lite slave
//
// Behaviour
// - Two 24-bit operands and carry flag, read/write
// - 8-bit control register groups carry, unit, length
// - Unit select write-only: binary, digit, byte
// - 5-bit length read/write, largest value 24
// - Sum with carry, difference with borrow
// - Read-only OR, XOR and AND results
// - Complement and mask limited to length
// - State group plus carry and borrow levels
// - Binary and comparison condition groups
`timescale 1ns/1ps
`include "afb_cfg.svh"
module afb_top
  import afb_pkg::*;
#(
  parameter int WIDTH = 24
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output afb_result_type   result
);
  // ******************************************************
  // Length mask
  // ******************************************************
  function automatic logic [23:0] len_mask(input logic [4:0] len);
    logic [4:0] n;
    n = (len > `AFB_LEN_MAX) ? `AFB_LEN_MAX : len;
    len_mask = 24'((25'h1 << n) - 25'h1);
  endfunction

  function automatic logic [31:0] pad24(input logic [23:0] v);
    pad24 = {8'h00, v};
  endfunction

  afb_bus_type  bus;
  afb_bus_type  next_bus;
  afb_regs_type regs;
  afb_regs_type next_regs;
  logic [23:0]  mask;
  logic [23:0]  sum_w;
  logic [23:0]  difference_out_w;
  logic         cyl_w;
  logic         cyd_w;
  logic [3:0]   binary_condition_group_w;
  logic [3:0]   operand_compare_group_w;
  logic [3:0]   operand_state_group_w;

  // ******************************************************
  // Arithmetic and conditions
  // ******************************************************
  // add and subtract
  afb_adder #(
    .WIDTH(WIDTH)
  ) u_adder (
    .first_operand    (regs.first_operand),
    .second_operand   (regs.second_operand),
    .carry_in_flag    (regs.ctrl.carry_in_flag),
    .unit             (regs.ctrl.unit),
    .sum_out          (sum_w),
    .difference_out   (difference_out_w),
    .carry_out_level  (cyl_w),
    .borrow_out_level (cyd_w)
  );

  afb_cond #(
    .WIDTH(WIDTH)
  ) u_cond (
    .first_operand          (regs.first_operand),
    .second_operand         (regs.second_operand),
    .sum_out                (sum_w),
    .carry_out_level        (cyl_w),
    .borrow_out_level       (cyd_w),
    .binary_condition_group (binary_condition_group_w),
    .operand_compare_group  (operand_compare_group_w),
    .operand_state_group    (operand_state_group_w)
  );

  always_comb begin
    mask = len_mask(regs.ctrl.operand_length);
    result.sum_out = sum_w;
    result.difference_out = difference_out_w;
    result.or_result = regs.first_operand | regs.second_operand;
    result.exclusive_or_result = regs.first_operand ^ regs.second_operand;
    result.and_result = regs.first_operand & regs.second_operand;
    result.first_complement = ~regs.first_operand & mask;
    result.second_complement = ~regs.second_operand & mask;
    result.first_masked = regs.first_operand & mask;
    result.second_masked = regs.second_operand & mask;
    result.operand_state_group = operand_state_group_w;
    result.carry_out_level = cyl_w;
    result.borrow_out_level = cyd_w;
    result.binary_condition_group = binary_condition_group_w;
    result.operand_compare_group = operand_compare_group_w;
  end

  // ******************************************************
  // Bus slave
  // ******************************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = regs.rdata;

  always_comb begin
    next_bus = bus;
    next_regs = regs;
    // Data phase of a write
    if (bus.phase == afb_st_data && bus.write) begin
      case (bus.addr)
        `AFB_OFF_FIRST: begin
          next_regs.first_operand = hwdata[23:0];
        end
        `AFB_OFF_SECOND: begin
          next_regs.second_operand = hwdata[23:0];
        end
        `AFB_OFF_CTRL: begin
          next_regs.ctrl.carry_in_flag = hwdata[`AFB_CTRL_CARRY];
          next_regs.ctrl.unit = afb_unit_type'(hwdata[`AFB_CTRL_UNIT_HI:`AFB_CTRL_UNIT_LO]);
          next_regs.ctrl.operand_length =
            (hwdata[`AFB_CTRL_LEN_HI:`AFB_CTRL_LEN_LO] > `AFB_LEN_MAX) ?
            `AFB_LEN_MAX : hwdata[`AFB_CTRL_LEN_HI:`AFB_CTRL_LEN_LO];
        end
        default: begin
          next_regs.rdata = regs.rdata;
        end
      endcase
    end
    // Address phase
    if (hsel && hready && htrans[1]) begin
      next_bus.phase = afb_st_data;
      next_bus.write = hwrite;
      next_bus.addr = {haddr[7:2], 2'b00};
      next_regs.rdata = 32'h00000000;
      if (!hwrite) begin
        case ({haddr[7:2], 2'b00})
          `AFB_OFF_FIRST:  next_regs.rdata = pad24(regs.first_operand);
          `AFB_OFF_SECOND: next_regs.rdata = pad24(regs.second_operand);
          `AFB_OFF_CTRL: begin
            next_regs.rdata = {24'h000000, regs.ctrl.operand_length, 2'b00,
                               regs.ctrl.carry_in_flag};
          end
          `AFB_OFF_SUM:    next_regs.rdata = pad24(result.sum_out);
          `AFB_OFF_DIFFERENCE_OUT:   next_regs.rdata = pad24(result.difference_out);
          `AFB_OFF_OR:     next_regs.rdata = pad24(result.or_result);
          `AFB_OFF_XOR:    next_regs.rdata = pad24(result.exclusive_or_result);
          `AFB_OFF_AND:    next_regs.rdata = pad24(result.and_result);
          `AFB_OFF_CMP1:   next_regs.rdata = pad24(result.first_complement);
          `AFB_OFF_CMP2:   next_regs.rdata = pad24(result.second_complement);
          `AFB_OFF_MSK1:   next_regs.rdata = pad24(result.first_masked);
          `AFB_OFF_MSK2:   next_regs.rdata = pad24(result.second_masked);
          `AFB_OFF_COND: begin
            next_regs.rdata = {18'h00000, result.borrow_out_level,
                               result.carry_out_level, result.operand_state_group,
                               result.operand_compare_group,
                               result.binary_condition_group};
          end
          default:         next_regs.rdata = 32'h00000000;
        endcase
      end
    end else if (hready) begin
      next_bus.phase = afb_st_idle;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus <= '{phase: afb_st_idle, write: 1'b0, addr: 8'h00};
      regs <= '{first_operand: `AFB_RST_OPERAND, second_operand: `AFB_RST_OPERAND,
                ctrl: `AFB_RST_CTRL, rdata: 32'h00000000};
    end else begin
      bus <= next_bus;
      regs <= next_regs;
    end
  end
endmodule

// ### sim/afb_checker.sv
// Assertion checker of the function box
`timescale 1ns/1ps
module afb_checker
  import afb_pkg::*;
(
  input wire logic           hclk,
  input wire logic           hresetn,
  input wire logic           hsel,
  input wire logic [31:0]    haddr,
  input wire logic [1:0]     htrans,
  input wire logic           hwrite,
  input wire logic [2:0]     hsize,
  input wire logic [31:0]    hwdata,
  input wire logic           hready,
  input wire logic [31:0]    hrdata,
  input wire logic           hreadyout,
  input wire logic           hresp,
  input wire afb_result_type result
);
  // ****
  // Shadow of the bus writes
  // ****
  logic [23:0] x, y;
  logic        c, pv, pw;
  logic [1:0]  u;
  logic [4:0]  len;
  logic [5:0]  pa;
  logic        wr;
  wire  [23:0] msk = (24'h1 << len) - 24'h1;
  wire  [24:0] sum = {1'b0, x} + {1'b0, y} + {24'h0, c};
  wire  [24:0] dif = {1'b0, x} - {1'b0, y} - {24'h0, c};
  assign wr = pv && pw && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {pv, pw, pa, x, y, c, u} <= '0;
      len <= 5'h18;
    end else begin
      if (hready) begin
        pv <= hsel && htrans[1];
        pw <= hwrite;
        pa <= haddr[7:2];
      end
      if (wr && pa == 6'h0) x <= hwdata[23:0];
      if (wr && pa == 6'h1) y <= hwdata[23:0];
      if (wr && pa == 6'h2) begin
        {u, c} <= hwdata[2:0];
        len <= (hwdata[7:3] > 5'h18) ? 5'h18 : hwdata[7:3];
      end
    end
  end
  // ****
  // Assertions
  // ****
  default clocking dck @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_read(logic [5:0] k);
    hsel && hready && htrans[1] && !hwrite && haddr[7:2] == k ##1 hready;
  endsequence
  a_read_first: assert property (s_read(6'h0) |-> hrdata == {8'h00, x})
    else $error("first operand read wrong");
  a_read_ctrl: assert property (s_read(6'h2) |-> hrdata == {24'h0, len, 2'b00, c})
    else $error("control read wrong");
  a_sum_carry: assert property (u != 2'h1 |-> {result.carry_out_level, result.sum_out} == sum)
    else $error("sum wrong");
  a_difference_out_borrow: assert property (u != 2'h1 |->
    {result.borrow_out_level, result.difference_out} == dif) else $error("difference wrong");
  a_logic_ops: assert property (result.or_result == (x | y) &&
    result.exclusive_or_result == (x ^ y) && result.and_result == (x & y))
    else $error("logic results wrong");
  a_mask_ops: assert property (result.first_masked == (x & msk) &&
    result.second_complement == (~y & msk)) else $error("mask wrong");
  a_state_group: assert property (
    result.operand_state_group == {x == 0, y == 0, x[0], y[0]}) else $error("state wrong");
  a_compare_group: assert property (result.operand_compare_group ==
    {x > y, x < y, x == y, (x & y) == 0}) else $error("compare wrong");
  a_zero_wait: assert property (hreadyout && !hresp)
    else $error("wait or error response");
endmodule
bind afb_top afb_checker u_afb_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .result(result));

// ### sim/afb_master.sv
// Sequencer model driving the function box registers over the bus
`timescale 1ns/1ps
module afb_master (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic [31:0]      rd_data,
  output int               rd_count
);
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, rd_data} = '0;
    hsize = 3'h2;
    rd_count = 0;
  end
  // ****
  // One single transfer
  // ****
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (!hready);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hready);
    hwdata <= ~d;
    if (!w) begin
      rd_data <= hrdata;
      rd_count <= rd_count + 1;
    end
  endtask
endmodule

// ### sim/tb_top.sv
// Self-checking bench of the function box
`timescale 1ns/1ps
module tb_top
  import afb_pkg::*;
;
  logic           hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]    haddr, hwdata, hrdata, rd_data, w;
  logic [1:0]     htrans;
  logic [2:0]     hsize;
  logic [23:0]    ex, ey;
  logic           ec;
  logic [4:0]     el;
  logic [39:0]    q[$];
  logic [39:0]    e;
  afb_result_type result;
  int             rd_count, err_total, checks, cyc;
  integer         seed = 93890;

  afb_top u_afb_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .result(result));
  afb_master u_afb_master (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .rd_data(rd_data), .rd_count(rd_count));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // ****
  // Expected register words
  // ****
  function automatic logic [31:0] model(input logic [7:0] a);
    logic [24:0] s, d;
    logic [23:0] m;
    s = {1'b0, ex} + {1'b0, ey} + {24'h0, ec};
    d = {1'b0, ex} - {1'b0, ey} - {24'h0, ec};
    m = (24'h1 << el) - 24'h1;
    case (a)
      8'h00: model = {8'h0, ex};
      8'h04: model = {8'h0, ey};
      8'h08: model = {24'h0, el, 2'b00, ec};
      8'h0c: model = {8'h0, s[23:0]};
      8'h10: model = {8'h0, d[23:0]};
      8'h14: model = {8'h0, ex | ey};
      8'h18: model = {8'h0, ex ^ ey};
      8'h1c: model = {8'h0, ex & ey};
      8'h20: model = {8'h0, ~ex & m};
      8'h24: model = {8'h0, ~ey & m};
      8'h28: model = {8'h0, ex & m};
      8'h2c: model = {8'h0, ey & m};
      8'h30: model = {18'h0, d[24], s[24], ex == 0, ey == 0, ex[0], ey[0], ex > ey, ex < ey,
        ex == ey, (ex & ey) == 0, s[24], d[24], s[23], s[23:0] == 0};
      default: model = 32'h0;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_afb_master.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back({a, x});
    u_afb_master.xfer(1'b0, a, 32'h0);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****
  // Result watcher and timeout
  // ****
  initial forever begin
    @(rd_count);
    e = q.pop_front();
    checks++;
    if (rd_data !== e[31:0]) begin
      err_total++;
      $display("[ERR] hrdata %h exp %h got %h", e[39:32], e[31:0], rd_data);
    end
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      print_verdict;
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    hresetn = 1'b0;
    {ex, ey, ec} = '0;
    el = 5'h18;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'hc0);
    for (int i = 0; i < 12; i++) begin
      w = $random(seed);
      ex = w[23:0];
      wr(8'h00, w);
      w = (i == 1) ? w : $random(seed);
      ey = w[23:0];
      wr(8'h04, w);
      w = $random(seed);
      w[7:3] = (i == 0) ? 5'h00 : (i == 1) ? 5'h18 : (i == 2) ? 5'h19 : w[7:3];
      w[2:1] = i[0] ? 2'h3 : 2'h0;
      ec = w[0];
      el = (w[7:3] > 5'h18) ? 5'h18 : w[7:3];
      wr(8'h08, w);
      for (int a = 0; a <= 'h30; a += 4) rd(a[7:0], model(a[7:0]));
    end
    wr(8'h34, w);
    wr(8'h0c, w);
    rd(8'h34, 32'h0);
    rd(8'h0c, model(8'h0c));
    wr(8'h00, 32'h99);
    wr(8'h04, 32'h01);
    wr(8'h08, 32'hc2);
    rd(8'h08, 32'hc0);
    rd(8'h0c, 32'h100);
    rd(8'h10, 32'h98);
    rd(8'h30, 32'h380);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'hc0);
    wr(8'h00, 32'h99);
    wr(8'h04, 32'h01);
    rd(8'h0c, 32'h9a);
    repeat (4) @(posedge hclk);
    print_verdict;
  end
endmodule
